// ### config_fuse_signature_loader.sv
// Signature row, fuse image access and reset-time fuse loader
`timescale 1ns/100ps
// Operation
// RL1 - Three read-only part identifier bytes at signature offsets 0 to 2
// RL2 - Ten read-only unique serial bytes at signature offsets 3 to 12
// RL3 - Temperature gain and signed offset correction bytes at 0x20 and 0x21
// RL4 - Signed low-frequency oscillator errors at 0x22 and 0x23
// RL5 - Signed high-frequency oscillator errors at 0x24 and 0x25
// RL6 - Reset copies watchdog fuse bits 7:4 to window field
// RL7 - Reset copies watchdog fuse bits 3:0 to period field
// RL8 - Brown-out settings reload only after power-on reset
// RL9 - Brown-out fuse bits 7:5 load threshold level
// RL10 - Brown-out fuse bit 4 loads sample rate select
// RL11 - Brown-out fuse bits 3:2 load active and idle mode
// RL12 - Brown-out fuse bits 1:0 load sleep mode
// RL13 - CPU and programming port read fuses; only programming port writes
// RL14 - New fuse values act only after the next reset
// RL15 - All copies finish before internal reset is released
module config_fuse_signature_loader
   import fuse_loader_pkg::*;
#(
   parameter int FUSE_DEPTH = 16,
   parameter logic [PART_ID_BYTES*8-1:0] PART_ID = 24'h5a_a5_01,        // Arbitrary value
   parameter logic [SERIAL_BYTES*8-1:0]  SERIAL  = 80'h09_08_07_06_05_04_03_02_01_00, // Arbitrary
   parameter logic [7:0]                 TEMP_GAIN = 8'h80,
   parameter logic [7:0]                 TEMP_OFFSET = 8'h00,
   parameter logic [7:0]                 OSC_LF_LV = 8'h00,
   parameter logic [7:0]                 OSC_LF_HV = 8'h00,
   parameter logic [7:0]                 OSC_HF_LV = 8'h00,
   parameter logic [7:0]                 OSC_HF_HV = 8'h00
) (
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              ext_reset_req_i,
   input  wire logic              cpu_rd_i,
   input  wire logic              cpu_sig_space_i,
   input  wire logic [ADDR_W-1:0] cpu_addr_i,
   output logic                   cpu_ready_o,
   output logic                   cpu_rvalid_o,
   output logic      [DATA_W-1:0] cpu_rdata_o,
   input  wire logic              prog_rd_i,
   input  wire logic              prog_we_i,
   input  wire logic              prog_sig_space_i,
   input  wire logic [ADDR_W-1:0] prog_addr_i,
   input  wire logic [DATA_W-1:0] prog_wdata_i,
   output logic                   prog_ready_o,
   output logic                   prog_rvalid_o,
   output logic      [DATA_W-1:0] prog_rdata_o,
   output logic                   sys_rst_b_o,
   output logic      [3:0]        wdt_window_o,
   output logic      [3:0]        wdt_period_o,
   output logic      [2:0]        bod_level_o,
   output logic                   bod_sample_rate_o,
   output logic      [1:0]        bod_active_mode_o,
   output logic      [1:0]        bod_sleep_mode_o,
   output logic                   bod_cfg_odd_o
);

   typedef struct packed {
      loader_state_t state;
      logic          por_pending;
      logic          sys_run;
      logic [3:0]    wdt_window;
      logic [3:0]    wdt_period;
      logic [2:0]    bod_level;
      logic          bod_sample;
      logic [1:0]    bod_active;
      logic [1:0]    bod_sleep;
      logic          cpu_p1;
      logic          prog_p1;
      logic          sig_p1;
      logic          mapped_p1;
      logic [7:0]    sig_data1;
      logic          cpu_valid;
      logic          prog_valid;
      logic [7:0]    rdata;
   } core_t;

   localparam core_t CORE_RST = '{state: S_WDT_RD, por_pending: 1'b1, default: '0};

   localparam logic [FUSE_DEPTH*8-1:0] FUSE_INIT =
      (FUSE_DEPTH*8)'({FUSE_OTHER_RST, FUSE_LOCK_KEY_OFS == 4'ha ? FUSE_OTHER_RST : FUSE_OTHER_RST,
                      FUSE_OTHER_RST, FUSE_OTHER_RST, FUSE_OTHER_RST, FUSE_SYSTEM_ONE_RST,
                      FUSE_SYSTEM_ZERO_RST, FUSE_OTHER_RST, FUSE_OTHER_RST, FUSE_OSCILLATOR_RST,
                      FUSE_BROWNOUT_RST, FUSE_WATCHDOG_RST});

   core_t             cur_reg;
   core_t             cur_next;
   logic              reset_req_sync;
   logic              prog_req;
   logic              cpu_take;
   logic              prog_take;
   logic [3:0]        mem_addr;
   logic              mem_we;
   logic [7:0]        mem_rdata;
   logic [ADDR_W-1:0] req_addr;
   logic              req_sig;

   generate
      if (FUSE_DEPTH < FUSE_COUNT || FUSE_DEPTH > 16) begin : g_bad_depth
         $error("FUSE_DEPTH must cover the fuse map and fit four address bits");
      end
   endgenerate

   // Signature row lookup, read-only by construction
   function automatic logic [7:0] sig_byte(input logic [ADDR_W-1:0] a);
      logic [7:0] b;
      b = 8'h00;
      if (a < SIG_SERIAL_OFS) begin
         b = PART_ID[a*8 +: 8]; // RL1
      end else if (a < SIG_SERIAL_OFS + 6'(SERIAL_BYTES)) begin
         b = SERIAL[(a - SIG_SERIAL_OFS)*8 +: 8]; // RL2
      end else begin
         case (a)
            SIG_TEMP_GAIN_OFS:                   b = TEMP_GAIN;   // RL3
            SIG_TEMP_OFFSET_OFS:                 b = TEMP_OFFSET; // RL3
            SIG_OSC_LOW_FREQ_ERR_LOW_VOLT_OFS:   b = OSC_LF_LV;   // RL4
            SIG_OSC_LOW_FREQ_ERR_HIGH_VOLT_OFS:  b = OSC_LF_HV;   // RL4
            SIG_OSC_HIGH_FREQ_ERR_LOW_VOLT_OFS:  b = OSC_HF_LV;   // RL5
            SIG_OSC_HIGH_FREQ_ERR_HIGH_VOLT_OFS: b = OSC_HF_HV;   // RL5
            default:                             b = 8'h00;
         endcase
      end
      return b;
   endfunction : sig_byte

   // Fuse offsets that hold a real fuse; reserved holes read zero, ignore writes
   function automatic logic fuse_mapped(input logic [ADDR_W-1:0] a);
      logic m;
      m = 1'b0;
      case (a)
         6'(FUSE_WATCHDOG_OFS), 6'(FUSE_BROWNOUT_OFS), 6'(FUSE_OSCILLATOR_OFS),
         6'(FUSE_SYSTEM_ZERO_OFS), 6'(FUSE_SYSTEM_ONE_OFS), 6'(FUSE_APPLICATION_END_OFS),
         6'(FUSE_BOOT_END_OFS), 6'(FUSE_LOCK_KEY_OFS): m = 1'b1;
         default: m = 1'b0;
      endcase
      return m;
   endfunction : fuse_mapped

   level_sync u_reset_req_sync (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .async_i (ext_reset_req_i),
      .sync_o  (reset_req_sync)
   );

   fuse_image_mem #(
      .DATA_W (DATA_W),
      .DEPTH  (FUSE_DEPTH),
      .ADDR_W (FUSE_ADDR_W),
      .INIT   (FUSE_INIT)
   ) u_fuse_image (
      .clk_i   (clk_i),
      .addr_i  (mem_addr),
      .we_i    (mem_we),
      .wdata_i (prog_wdata_i),
      .rdata_o (mem_rdata)
   );

   // Access arbitration: loader first, then programming port, then CPU
   assign prog_req     = prog_rd_i | prog_we_i;
   assign prog_ready_o = cur_reg.sys_run;
   assign cpu_ready_o  = cur_reg.sys_run & ~prog_req;
   assign prog_take    = prog_ready_o & prog_req;
   assign cpu_take     = cpu_ready_o & cpu_rd_i;
   assign req_addr     = prog_take ? prog_addr_i : cpu_addr_i;
   assign req_sig      = prog_take ? prog_sig_space_i : cpu_sig_space_i;

   // Fuse port address and write strobe
   always_comb begin
      mem_addr = req_addr[FUSE_ADDR_W-1:0];
      mem_we   = 1'b0;
      case (cur_reg.state)
         S_WDT_RD: mem_addr = FUSE_WATCHDOG_OFS;
         S_BOD_RD: mem_addr = FUSE_BROWNOUT_OFS;
         S_RUN: begin
            // Only the programming port can change a fuse
            mem_we = prog_take & prog_we_i & ~prog_sig_space_i & fuse_mapped(prog_addr_i); // RL13
         end
         default: mem_addr = req_addr[FUSE_ADDR_W-1:0];
      endcase
   end

   // Loader sequence and read pipeline
   always_comb begin
      cur_next = cur_reg;
      cur_next.cpu_p1     = 1'b0;
      cur_next.prog_p1    = 1'b0;
      cur_next.cpu_valid  = cur_reg.cpu_p1;
      cur_next.prog_valid = cur_reg.prog_p1;
      cur_next.rdata      = cur_reg.sig_p1 ? cur_reg.sig_data1 : (cur_reg.mapped_p1 ? mem_rdata : 8'h00);
      case (cur_reg.state)
         S_WDT_RD: begin
            cur_next.state = S_WDT_LD;
         end
         S_WDT_LD: begin
            // Watchdog fields load on every reset
            cur_next.wdt_window = mem_rdata[WDT_WINDOW_MSB:WDT_WINDOW_LSB]; // RL6
            cur_next.wdt_period = mem_rdata[WDT_PERIOD_MSB:WDT_PERIOD_LSB]; // RL7
            // Brown-out fields only after power-on; otherwise left as they were
            cur_next.state = cur_reg.por_pending ? S_BOD_RD : S_RUN; // RL8
         end
         S_BOD_RD: begin
            cur_next.state = S_BOD_LD;
         end
         S_BOD_LD: begin
            cur_next.bod_level   = mem_rdata[BOD_LEVEL_MSB:BOD_LEVEL_LSB];   // RL9
            cur_next.bod_sample  = mem_rdata[BOD_SAMPLE_BIT];                // RL10
            cur_next.bod_active  = mem_rdata[BOD_ACTIVE_MSB:BOD_ACTIVE_LSB]; // RL11
            cur_next.bod_sleep   = mem_rdata[BOD_SLEEP_MSB:BOD_SLEEP_LSB];   // RL12
            cur_next.por_pending = 1'b0;
            cur_next.state       = S_RUN;
         end
         S_RUN: begin
            cur_next.cpu_p1    = cpu_take;
            cur_next.prog_p1   = prog_take & prog_rd_i & ~prog_we_i;
            cur_next.sig_p1    = req_sig;
            cur_next.mapped_p1 = fuse_mapped(req_addr); // RL13
            cur_next.sig_data1 = sig_byte(req_addr);
            if (reset_req_sync) begin
               cur_next.state = S_HOLD;
            end
         end
         S_HOLD: begin
            // Fresh fuse values are picked up only on the way out of reset
            if (!reset_req_sync) begin
               cur_next.state = S_WDT_RD; // RL14
            end
         end
         default: cur_next.state = S_WDT_RD;
      endcase
      // Release only once every copy has landed
      cur_next.sys_run = (cur_next.state == S_RUN); // RL15
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur_reg <= CORE_RST;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // Outputs
   assign sys_rst_b_o       = cur_reg.sys_run;
   assign cpu_rvalid_o      = cur_reg.cpu_valid;
   assign prog_rvalid_o     = cur_reg.prog_valid;
   assign cpu_rdata_o       = cur_reg.rdata;
   assign prog_rdata_o      = cur_reg.rdata;
   assign wdt_window_o      = cur_reg.wdt_window;
   assign wdt_period_o      = cur_reg.wdt_period;
   assign bod_level_o       = cur_reg.bod_level;
   assign bod_sample_rate_o = cur_reg.bod_sample;
   assign bod_active_mode_o = cur_reg.bod_active;
   assign bod_sleep_mode_o  = cur_reg.bod_sleep;
   // Flags a threshold without a typical figure or the reserved sleep code
   assign bod_cfg_odd_o = ~(cur_reg.bod_level == THRESHOLD_CODE_ZERO || cur_reg.bod_level == THRESHOLD_CODE_TWO ||
                            cur_reg.bod_level == THRESHOLD_CODE_SEVEN) || (cur_reg.bod_sleep == MODE_RESERVED_SLEEP);

   // Checks
   a_part_id_read: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL1
      cpu_take && cpu_sig_space_i && cpu_addr_i == SIG_PART_ID_OFS |-> ##2 cpu_rdata_o == PART_ID[7:0])
      else $error("part identifier byte zero read wrong");
   a_serial_read: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL2
      cpu_take && cpu_sig_space_i && cpu_addr_i == SIG_SERIAL_OFS |-> ##2 cpu_rvalid_o && cpu_rdata_o == SERIAL[7:0])
      else $error("serial byte zero read wrong");
   a_temp_gain_read: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL3
      prog_take && prog_rd_i && !prog_we_i && prog_sig_space_i && prog_addr_i == SIG_TEMP_GAIN_OFS
      |-> ##2 prog_rvalid_o && prog_rdata_o == TEMP_GAIN)
      else $error("temperature gain byte read wrong");
   a_osc_err_read: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL4
      cpu_take && cpu_sig_space_i && cpu_addr_i == SIG_OSC_LOW_FREQ_ERR_HIGH_VOLT_OFS |-> ##2 cpu_rdata_o == OSC_LF_HV)
      else $error("oscillator error byte read wrong");
   a_osc_hf_read: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL5
      cpu_take && cpu_sig_space_i && cpu_addr_i == SIG_OSC_HIGH_FREQ_ERR_LOW_VOLT_OFS |-> ##2 cpu_rdata_o == OSC_HF_LV)
      else $error("high frequency oscillator error read wrong");
   a_wdt_window_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL6
      cur_reg.state == S_WDT_LD |=> wdt_window_o == $past(mem_rdata[7:4]))
      else $error("watchdog window not loaded from fuse");
   a_wdt_period_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL7
      cur_reg.state == S_WDT_LD |=> wdt_period_o == $past(mem_rdata[3:0]))
      else $error("watchdog period not loaded from fuse");
   a_bod_kept_warm: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL8
      !cur_reg.por_pending |=> $stable(bod_level_o) && $stable(bod_active_mode_o) && $stable(bod_sleep_mode_o))
      else $error("brown-out settings changed without power-on reset");
   a_bod_level_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL9
      cur_reg.state == S_BOD_LD |=> bod_level_o == $past(mem_rdata[7:5]))
      else $error("brown-out threshold not loaded");
   a_bod_rate_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL10
      cur_reg.state == S_BOD_LD |=> bod_sample_rate_o == $past(mem_rdata[4]))
      else $error("brown-out sample rate not loaded");
   a_bod_active_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL11
      cur_reg.state == S_BOD_LD |=> bod_active_mode_o == $past(mem_rdata[3:2]))
      else $error("brown-out active mode not loaded");
   a_bod_sleep_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL12
      cur_reg.state == S_BOD_LD |=> bod_sleep_mode_o == $past(mem_rdata[1:0]))
      else $error("brown-out sleep mode not loaded");
   a_write_only_prog: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL13
      mem_we |-> prog_we_i && !prog_sig_space_i && sys_rst_b_o)
      else $error("fuse written by other than programming port");
   a_cfg_frozen_run: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL14
      sys_rst_b_o && $past(sys_rst_b_o) |-> $stable(wdt_window_o) && $stable(wdt_period_o))
      else $error("configuration changed while running");
   a_release_after_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL15
      $rose(sys_rst_b_o) |-> $past(cur_reg.state) == S_WDT_LD || $past(cur_reg.state) == S_BOD_LD)
      else $error("internal reset released before loading");
   // Remaining signature bytes, read answers, held settings and reset hold
   a_part_id_top: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL1
      cpu_take && cpu_sig_space_i && cpu_addr_i == 6'(PART_ID_BYTES - 1) |-> ##2 cpu_rdata_o == PART_ID[23:16])
      else $error("part identifier top byte read wrong");
   a_serial_top_read: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL2
      prog_take && prog_rd_i && !prog_we_i && prog_sig_space_i && prog_addr_i == SIG_SERIAL_OFS + 6'(SERIAL_BYTES - 1)
      |-> ##2 prog_rvalid_o && prog_rdata_o == SERIAL[79:72])
      else $error("serial top byte read wrong");
   a_temp_offset_read: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL3
      cpu_take && cpu_sig_space_i && cpu_addr_i == SIG_TEMP_OFFSET_OFS |-> ##2 cpu_rdata_o == TEMP_OFFSET)
      else $error("temperature offset byte read wrong");
   a_osc_lf_read: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL4
      cpu_take && cpu_sig_space_i && cpu_addr_i == SIG_OSC_LOW_FREQ_ERR_LOW_VOLT_OFS |-> ##2 cpu_rdata_o == OSC_LF_LV)
      else $error("low frequency error byte read wrong");
   a_osc_hf_hv_read: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL5
      cpu_take && cpu_sig_space_i && cpu_addr_i == SIG_OSC_HIGH_FREQ_ERR_HIGH_VOLT_OFS |-> ##2 cpu_rdata_o == OSC_HF_HV)
      else $error("high frequency error byte read wrong");
   a_wdt_only_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL7
      cur_reg.state != S_WDT_LD |=> $stable(wdt_window_o) && $stable(wdt_period_o))
      else $error("watchdog fields changed outside load");
   a_bod_only_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL10
      cur_reg.state != S_BOD_LD |=> $stable(bod_sample_rate_o) && $stable(bod_level_o))
      else $error("brown-out fields changed outside load");
   a_cpu_answer: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL13
      cpu_take |-> ##2 cpu_rvalid_o)
      else $error("cpu read not answered");
   a_prog_answer: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL13
      prog_take && prog_rd_i && !prog_we_i |-> ##2 prog_rvalid_o)
      else $error("programming port read not answered");
   a_hold_on_request: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL14
      sys_rst_b_o && reset_req_sync |=> !sys_rst_b_o)
      else $error("reset request did not hold the system");
   a_ready_in_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL15
      !sys_rst_b_o |-> !cpu_ready_o && !prog_ready_o)
      else $error("access ready while held in reset");
endmodule : config_fuse_signature_loader

// ### fuse_loader_pkg.sv
// Shared constants and types for the signature row, fuse image and reset-time loader
package fuse_loader_pkg;

   // Bus widths and fuse count
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int FUSE_ADDR_W = 4;
   localparam int FUSE_COUNT = 11;

   // Signature row offsets
   localparam logic [5:0] SIG_PART_ID_OFS = 6'h00;
   localparam int         PART_ID_BYTES = 3;
   localparam logic [5:0] SIG_SERIAL_OFS = 6'h03;
   localparam int         SERIAL_BYTES = 10;
   localparam logic [5:0] SIG_TEMP_GAIN_OFS = 6'h20;
   localparam logic [5:0] SIG_TEMP_OFFSET_OFS = 6'h21;
   localparam logic [5:0] SIG_OSC_LOW_FREQ_ERR_LOW_VOLT_OFS = 6'h22;
   localparam logic [5:0] SIG_OSC_LOW_FREQ_ERR_HIGH_VOLT_OFS = 6'h23;
   localparam logic [5:0] SIG_OSC_HIGH_FREQ_ERR_LOW_VOLT_OFS = 6'h24;
   localparam logic [5:0] SIG_OSC_HIGH_FREQ_ERR_HIGH_VOLT_OFS = 6'h25;

   // Fuse offsets
   localparam logic [3:0] FUSE_WATCHDOG_OFS = 4'h0;
   localparam logic [3:0] FUSE_BROWNOUT_OFS = 4'h1;
   localparam logic [3:0] FUSE_OSCILLATOR_OFS = 4'h2;
   localparam logic [3:0] FUSE_SYSTEM_ZERO_OFS = 4'h5;
   localparam logic [3:0] FUSE_SYSTEM_ONE_OFS = 4'h6;
   localparam logic [3:0] FUSE_APPLICATION_END_OFS = 4'h7;
   localparam logic [3:0] FUSE_BOOT_END_OFS = 4'h8;
   localparam logic [3:0] FUSE_LOCK_KEY_OFS = 4'ha;

   // Fuse delivery values of the nonvolatile image
   localparam logic [7:0] FUSE_WATCHDOG_RST = 8'h00;
   localparam logic [7:0] FUSE_BROWNOUT_RST = 8'h00;
   localparam logic [7:0] FUSE_OSCILLATOR_RST = 8'h02;
   localparam logic [7:0] FUSE_SYSTEM_ZERO_RST = 8'hc4;
   localparam logic [7:0] FUSE_SYSTEM_ONE_RST = 8'h07;
   localparam logic [7:0] FUSE_OTHER_RST = 8'h00;

   // Watchdog fuse fields
   localparam int WDT_WINDOW_MSB = 7;
   localparam int WDT_WINDOW_LSB = 4;
   localparam int WDT_PERIOD_MSB = 3;
   localparam int WDT_PERIOD_LSB = 0;

   // Brown-out fuse fields
   localparam int BOD_LEVEL_MSB = 7;
   localparam int BOD_LEVEL_LSB = 5;
   localparam int BOD_SAMPLE_BIT = 4;
   localparam int BOD_ACTIVE_MSB = 3;
   localparam int BOD_ACTIVE_LSB = 2;
   localparam int BOD_SLEEP_MSB = 1;
   localparam int BOD_SLEEP_LSB = 0;

   // Threshold and mode codes
   localparam logic [2:0] THRESHOLD_CODE_ZERO = 3'h0;
   localparam logic [2:0] THRESHOLD_CODE_TWO = 3'h2;
   localparam logic [2:0] THRESHOLD_CODE_SEVEN = 3'h7;
   localparam logic [1:0] MODE_RESERVED_SLEEP = 2'h3;

   // Loader states, Gray coded along the power-on load path
   typedef enum logic [2:0] {
      S_WDT_RD = 3'b000,
      S_WDT_LD = 3'b001,
      S_BOD_RD = 3'b011,
      S_BOD_LD = 3'b010,
      S_RUN    = 3'b110,
      S_HOLD   = 3'b111
   } loader_state_t;

endpackage : fuse_loader_pkg

// ### level_sync.sv
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/100ps
module level_sync (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_reg <= 1'b0;
         sync_o   <= 1'b0;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule : level_sync

// ### fuse_image_mem.sv
// Nonvolatile fuse image: one port, registered read data
`timescale 1ns/100ps
module fuse_image_mem #(
   parameter int DATA_W = 8,
   parameter int DEPTH  = 16,
   parameter int ADDR_W = 4,
   parameter logic [DEPTH*DATA_W-1:0] INIT = '0
) (
   input  wire logic              clk_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              we_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   output logic      [DATA_W-1:0] rdata_o
);
   logic [DATA_W-1:0] cells [DEPTH];

   // Contents are not touched by any reset
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         cells[i] = INIT[i*DATA_W +: DATA_W];
      end
   end

   // Write through the single port, read registered
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         cells[addr_i] <= wdata_i;
      end
      rdata_o <= cells[addr_i];
   end

   generate
      if (DEPTH > (1 << ADDR_W)) begin : g_bad_depth
         $error("fuse_image_mem depth exceeds address range");
      end
   endgenerate
endmodule : fuse_image_mem

// ### cfg_receiver.sv
// Watchdog and brown-out stand-in that keeps the settings it was handed at reset release
`timescale 1ns/100ps
module cfg_receiver (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_b_i,
   input  wire logic [16:0] cfg_i,
   output logic      [16:0] held_o
);
   logic run_q;

   // Take the settings once, on the first edge after the internal reset lifts
   always_ff @(posedge clk_i) begin
      run_q <= sys_rst_b_i;
      if (sys_rst_b_i && !run_q) begin
         held_o <= cfg_i;
      end
   end
endmodule : cfg_receiver

// ### config_fuse_signature_loader_tb.sv
// Self-checking bench for the signature row, fuse access and reset-time loader
`timescale 1ns/100ps
module config_fuse_signature_loader_tb;
   import fuse_loader_pkg::*;
   localparam logic [23:0] PID = 24'h3c_2b_1a; // Arbitrary value
   localparam logic [79:0] SER = 80'h9a_89_78_67_56_45_34_23_12_01;
   localparam logic [47:0] CAL = 48'hf6_05_fe_03_11_c8;
   logic        clk_i, rst_b_i, ext_reset_req_i;
   logic        cpu_rd_i, cpu_sig_space_i, cpu_ready_o, cpu_rvalid_o;
   logic [5:0]  cpu_addr_i, prog_addr_i;
   logic [7:0]  cpu_rdata_o, prog_rdata_o, prog_wdata_i;
   logic        prog_rd_i, prog_we_i, prog_sig_space_i, prog_ready_o, prog_rvalid_o;
   logic        sys_rst_b_o, bod_sample_rate_o, bod_cfg_odd_o;
   logic [3:0]  wdt_window_o, wdt_period_o;
   logic [2:0]  bod_level_o;
   logic [1:0]  bod_active_mode_o, bod_sleep_mode_o;
   logic [16:0] cfg, held;
   logic [7:0]  prev_bod;
   logic [7:0]  wdt_tab [4] = '{8'ha5, 8'h3c, 8'hf0, 8'h0f};
   logic [7:0]  bod_tab [4] = '{8'he9, 8'h5f, 8'h06, 8'h30};
   int          mismatches, n_tests;

   assign cfg = {wdt_window_o, wdt_period_o, bod_level_o, bod_sample_rate_o,
                 bod_active_mode_o, bod_sleep_mode_o, bod_cfg_odd_o};

   config_fuse_signature_loader #(.PART_ID(PID), .SERIAL(SER), .TEMP_GAIN(CAL[7:0]),
      .TEMP_OFFSET(CAL[15:8]), .OSC_LF_LV(CAL[23:16]), .OSC_LF_HV(CAL[31:24]),
      .OSC_HF_LV(CAL[39:32]), .OSC_HF_HV(CAL[47:40])) u_config_fuse_signature_loader (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .ext_reset_req_i(ext_reset_req_i),
      .cpu_rd_i(cpu_rd_i), .cpu_sig_space_i(cpu_sig_space_i), .cpu_addr_i(cpu_addr_i),
      .cpu_ready_o(cpu_ready_o), .cpu_rvalid_o(cpu_rvalid_o), .cpu_rdata_o(cpu_rdata_o),
      .prog_rd_i(prog_rd_i), .prog_we_i(prog_we_i), .prog_sig_space_i(prog_sig_space_i),
      .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i), .prog_ready_o(prog_ready_o),
      .prog_rvalid_o(prog_rvalid_o), .prog_rdata_o(prog_rdata_o), .sys_rst_b_o(sys_rst_b_o),
      .wdt_window_o(wdt_window_o), .wdt_period_o(wdt_period_o), .bod_level_o(bod_level_o),
      .bod_sample_rate_o(bod_sample_rate_o), .bod_active_mode_o(bod_active_mode_o),
      .bod_sleep_mode_o(bod_sleep_mode_o), .bod_cfg_odd_o(bod_cfg_odd_o));

   cfg_receiver u_cfg_receiver (.clk_i(clk_i), .sys_rst_b_i(sys_rst_b_o), .cfg_i(cfg), .held_o(held));

   // Expected loader outputs for a given pair of fuse bytes
   function automatic logic [16:0] exp_cfg(input logic [7:0] w, input logic [7:0] b);
      logic odd;
      odd = !(b[7:5] inside {3'h0, 3'h2, 3'h7}) || (b[1:0] == 2'h3);
      return {w, b, odd};
   endfunction : exp_cfg

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t byte got %h expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_cfg(input logic [16:0] got, input logic [16:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t settings got %h expected %h", $time, got, exp);
      end
   endtask : chk_cfg

   // Wait, bounded, until the design's ready for the chosen port is high
   task automatic wait_ready(input bit prog);
      int i;
      i = 0;
      while (((prog ? prog_ready_o : cpu_ready_o) !== 1'b1) && i < 50) begin
         @(posedge clk_i);
         #1;
         i++;
      end
   endtask : wait_ready

   // One byte read on either port, answer checked while its valid pulse stands
   task automatic rd(input bit prog, input logic sig, input logic [5:0] addr, input logic [7:0] exp);
      @(posedge clk_i);
      #1;
      cpu_rd_i = !prog;
      prog_rd_i = prog;
      cpu_sig_space_i = sig;
      prog_sig_space_i = sig;
      cpu_addr_i = addr;
      prog_addr_i = addr;
      wait_ready(prog);
      @(posedge clk_i);
      #1;
      cpu_rd_i = 1'b0;
      prog_rd_i = 1'b0;
      @(posedge clk_i);
      #1;
      chk_byte({7'h00, prog ? prog_rvalid_o : cpu_rvalid_o}, 8'h01);
      chk_byte(prog ? prog_rdata_o : cpu_rdata_o, exp);
   endtask : rd

   task automatic wr(input logic sig, input logic [5:0] addr, input logic [7:0] data);
      @(posedge clk_i);
      #1;
      prog_we_i = 1'b1;
      prog_sig_space_i = sig;
      prog_addr_i = addr;
      prog_wdata_i = data;
      wait_ready(1'b1);
      @(posedge clk_i);
      #1;
      prog_we_i = 1'b0;
   endtask : wr

   // Wait, bounded, for the internal reset to reach a level
   task automatic wait_sys(input logic lvl);
      int i;
      i = 0;
      while (sys_rst_b_o !== lvl && i < 100) begin
         @(posedge clk_i);
         #1;
         i++;
      end
      chk_byte({7'h00, sys_rst_b_o}, {7'h00, lvl});
   endtask : wait_sys

   task automatic tally_and_finish;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // Watchdog against a hung run
   initial begin
      #400000;
      mismatches++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      {rst_b_i, ext_reset_req_i, cpu_rd_i, cpu_sig_space_i, prog_rd_i, prog_we_i} = '0;
      {prog_sig_space_i, cpu_addr_i, prog_addr_i, prog_wdata_i} = '0;
      mismatches = 0;
      n_tests = 0;
      repeat (10) @(posedge clk_i);
      #1;
      chk_cfg({sys_rst_b_o, cfg[15:0]}, 17'h0);
      rst_b_i = 1'b1;
      wait_sys(1'b1);
      chk_cfg(cfg, 17'h0);
      for (int k = 0; k < 3; k++) rd(0, 1'b1, 6'(k), PID[8*k+:8]);
      for (int k = 0; k < 10; k++) rd(k[0], 1'b1, 6'(3 + k), SER[8*k+:8]);
      for (int k = 0; k < 6; k++) rd(k == 0, 1'b1, 6'(32 + k), CAL[8*k+:8]);
      rd(0, 1'b1, 6'h0d, 8'h00);
      rd(1, 1'b0, 6'h02, 8'h02);
      rd(0, 1'b0, 6'h05, 8'hc4);
      rd(0, 1'b0, 6'h03, 8'h00);
      wr(1'b1, 6'h00, 8'hff);
      rd(0, 1'b1, 6'h00, PID[7:0]);
      prev_bod = 8'h00;
      for (int k = 0; k < 4; k++) begin
         wr(1'b0, 6'h00, wdt_tab[k]);
         wr(1'b0, 6'h01, bod_tab[k]);
         rd(0, 1'b0, 6'h01, bod_tab[k]);
         rd(1, 1'b0, 6'h00, wdt_tab[k]);
         chk_cfg(cfg, k == 0 ? 17'h0 : exp_cfg(wdt_tab[k-1], prev_bod));
         ext_reset_req_i = 1'b1;
         wait_sys(1'b0);
         ext_reset_req_i = 1'b0;
         wait_sys(1'b1);
         chk_cfg(cfg, exp_cfg(wdt_tab[k], prev_bod));
         @(posedge clk_i);
         #1;
         rst_b_i = 1'b0;
         #1;
         chk_cfg({sys_rst_b_o, cfg[15:0]}, 17'h0);
         @(posedge clk_i);
         #1;
         rst_b_i = 1'b1;
         wait_sys(1'b1);
         chk_cfg(cfg, exp_cfg(wdt_tab[k], bod_tab[k]));
         @(posedge clk_i);
         #1;
         chk_cfg(held, cfg);
         prev_bod = bod_tab[k];
      end
      tally_and_finish();
   end
endmodule : config_fuse_signature_loader_tb
